// file: hdl/lohaps_cfg.svh
// Constants of the line overhead / APS / alarm block.
// Assumes a 250 MHz clock and a 32-bit classic Wishbone register port.
`ifndef LOHAPS_CFG_SVH
`define LOHAPS_CFG_SVH

// Register indices; byte address is four times the index
`define LOHAPS_IDX_TX_DIAG      6'h05
`define LOHAPS_IDX_TX_APS1      6'h06
`define LOHAPS_IDX_TX_APS2      6'h07
`define LOHAPS_IDX_RX_CTRL      6'h08
`define LOHAPS_IDX_RX_INT       6'h09
`define LOHAPS_IDX_AUX_CTRL     6'h1F

// Field positions
`define LOHAPS_B_B2_INJECT      0
`define LOHAPS_B_RDI_STATE      0
`define LOHAPS_B_AIS_STATE      1
`define LOHAPS_B_OUT_WORD       3
`define LOHAPS_B_RDI_PERSIST    4
`define LOHAPS_B_AIS_PERSIST    5
`define LOHAPS_B_FORCE_ONES     6
`define LOHAPS_B_CNT_WORD       7
`define LOHAPS_B_RDI_FLAG       0
`define LOHAPS_B_AIS_FLAG       1
`define LOHAPS_B_PAR_FLAG       2
`define LOHAPS_B_REI_FLAG       3
`define LOHAPS_B_AUTO_REI       0
`define LOHAPS_B_RING_EN        1
`define LOHAPS_B_APS_SEL        2
`define LOHAPS_B_RDI_EN         4
`define LOHAPS_B_AIS_EN         5
`define LOHAPS_B_PAR_EN         6
`define LOHAPS_B_REI_EN         7

// Reset values and codes
`define LOHAPS_RST_BYTE         8'h00
`define LOHAPS_ALL_ONES         8'hFF
`define LOHAPS_CODE_RDI         3'h6
`define LOHAPS_CODE_AIS         3'h7
`define LOHAPS_PERSIST_SHORT    3'h3
`define LOHAPS_PERSIST_LONG     3'h5
`define LOHAPS_CTRL_RW_MASK     8'hF8
`define LOHAPS_INT_EN_MASK      8'hF0

`endif

// file: hdl/lohaps_line_oh.sv
// Line overhead logic: B2 error injection, K1/K2 insertion, RDI/AIS
// detection, B2 error reporting and counting, clear-on-read flags.
// Assumes frame and slot strobes come from a framer on the same clock.
`timescale 1ns/100ps
`include "lohaps_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RQ1) Inject flips every transmitted B2 bit
// (RQ2) Register bit 7 goes out first
// (RQ3) K1 write loads both at frame boundary
// (RQ4) Software spaces K1 writes two frames
// (RQ5) Software writes K2 before K1
// (RQ6) Select bit picks registers or serial input
// (RQ7) RDI set/cleared after 3 or 5 frames
// (RQ8) AIS set/cleared after 3 or 5 frames
// (RQ9) RDI state in status and pin
// (RQ10) AIS state in status and pin
// (RQ11) Force receive bus ones during AIS
// (RQ12) Error pulse per frame or per bit
// (RQ13) Counter per frame or per bit
// (RQ14) Auto REI sends pulse count in Z2
// (RQ15) RDI change flag, cleared on read
// (RQ16) AIS change flag, cleared on read
// (RQ17) Parity error flag, cleared on read
// (RQ18) RDI change raises line interrupt
// (RQ19) AIS change raises line interrupt
// (RQ20) Parity error raises line interrupt
// (RQ21) REI raises line interrupt
// (RQ22) Nonzero received REI sets flag
// (RQ23) Interrupt follows enabled pending flags
module lohaps_line_oh (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  tx_frame_start,
  input  wire logic [7:0]            tx_in_byte,
  input  wire logic                  tx_b2_slot,
  input  wire logic                  tx_k1_slot,
  input  wire logic                  tx_k2_slot,
  input  wire logic                  tx_z2_slot,
  output logic      [7:0]            tx_out_byte,
  input  wire logic                  serial_aps_clk,
  input  wire logic                  serial_aps_input,
  input  wire logic                  rx_frame_start,
  input  wire logic [7:0]            rx_in_byte,
  input  wire logic [7:0]            rx_b2_calc,
  input  wire logic                  rx_b2_slot,
  input  wire logic                  rx_k2_slot,
  input  wire logic                  rx_z2_slot,
  output logic      [7:0]            receive_out_bus,
  output logic                       b2_error_pulse,
  output logic      [19:0]           b2_err_count,
  output logic                       remote_defect_state,
  output logic                       line_alarm_ind_out,
  output logic                       line_int
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] ones_in(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Next persistence count: counts frames that disagree with the state
  function automatic logic [2:0] persist_next(input logic [2:0] cnt,
                                              input logic       differs,
                                              input logic [2:0] thr);
    if (!differs || cnt == thr - 3'h1) begin
      return 3'h0;
    end
    return cnt + 3'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic                  inject_ff;
  lohaps_pkg::lohaps_byte_t aps1_ff;
  lohaps_pkg::lohaps_byte_t aps2_ff;
  lohaps_pkg::lohaps_byte_t aps1_act_ff;
  lohaps_pkg::lohaps_byte_t aps2_act_ff;
  logic                  aps_pend_ff;
  logic [7:3]            rx_ctrl_ff;
  logic [7:4]            int_en_ff;
  logic [2:0]            aux_ff;
  logic                  rdi_flag_ff;
  logic                  ais_flag_ff;
  logic                  par_flag_ff;
  logic                  rei_flag_ff;
  logic                  ack_ff;
  logic [31:0]           rdat_ff;

  // Bus decode
  logic [5:0]            idx;
  logic                  req;
  logic                  wr_now;
  logic                  rd_now;
  logic                  wr_lane;
  logic                  hit_diag;
  logic                  hit_aps1;
  logic                  hit_aps2;
  logic                  hit_ctrl;
  logic                  hit_int;
  logic                  hit_aux;
  logic                  int_read;
  logic [7:0]            rd_byte;

  assign idx      = wb_adr_i[7:2];
  assign req      = wb_cyc_i & wb_stb_i;
  // A write and a read side effect happen at the edge the master sees ack
  assign wr_now   = req & ack_ff & wb_we_i & wr_lane;
  assign rd_now   = req & ack_ff & ~wb_we_i;
  assign wr_lane  = wb_sel_i[0];
  assign hit_diag = (idx == `LOHAPS_IDX_TX_DIAG);
  assign hit_aps1 = (idx == `LOHAPS_IDX_TX_APS1);
  assign hit_aps2 = (idx == `LOHAPS_IDX_TX_APS2);
  assign hit_ctrl = (idx == `LOHAPS_IDX_RX_CTRL);
  assign hit_int  = (idx == `LOHAPS_IDX_RX_INT);
  assign hit_aux  = (idx == `LOHAPS_IDX_AUX_CTRL);
  assign int_read = rd_now & hit_int;

  // Decoded control fields
  logic                  out_word;
  logic                  cnt_word;
  logic                  force_ones;
  logic                  rdi_short;
  logic                  ais_short;
  logic                  auto_rei;
  logic                  ring_en;
  logic                  aps_sel;

  assign out_word   = rx_ctrl_ff[`LOHAPS_B_OUT_WORD];
  assign rdi_short  = rx_ctrl_ff[`LOHAPS_B_RDI_PERSIST];
  assign ais_short  = rx_ctrl_ff[`LOHAPS_B_AIS_PERSIST];
  assign force_ones = rx_ctrl_ff[`LOHAPS_B_FORCE_ONES];
  assign cnt_word   = rx_ctrl_ff[`LOHAPS_B_CNT_WORD];
  assign auto_rei   = aux_ff[`LOHAPS_B_AUTO_REI];
  assign ring_en    = aux_ff[`LOHAPS_B_RING_EN];
  assign aps_sel    = aux_ff[`LOHAPS_B_APS_SEL];

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, unmapped reads return zero

  logic                  rdi_ff;
  logic                  ais_ff;

  logic [7:0]            ctrl_rd;
  logic [7:0]            int_rd;
  assign ctrl_rd = {rx_ctrl_ff, 1'b0, ais_ff, rdi_ff};   // [RQ9] [RQ10]
  assign int_rd  = {int_en_ff, rei_flag_ff, par_flag_ff, ais_flag_ff, rdi_flag_ff};

  assign rd_byte = hit_diag ? {7'h00, inject_ff} :
                   hit_aps1 ? aps1_ff :
                   hit_aps2 ? aps2_ff :
                   hit_ctrl ? ctrl_rd :
                   hit_int  ? int_rd :
                   hit_aux  ? {5'h00, aux_ff} : `LOHAPS_RST_BYTE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff  <= req & ~ack_ff;
      rdat_ff <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inject_ff  <= 1'b0;
      aps1_ff    <= `LOHAPS_RST_BYTE;
      aps2_ff    <= `LOHAPS_RST_BYTE;
      rx_ctrl_ff <= 5'h00;
      int_en_ff  <= 4'h0;
      aux_ff     <= 3'h0;
    end else if (ce && wr_now) begin
      if (hit_diag) inject_ff <= wb_dat_i[`LOHAPS_B_B2_INJECT];
      if (hit_aps1) aps1_ff <= wb_dat_i[7:0];
      if (hit_aps2) aps2_ff <= wb_dat_i[7:0];
      if (hit_ctrl) rx_ctrl_ff <= wb_dat_i[7:3];
      if (hit_int)  int_en_ff <= wb_dat_i[7:4];
      if (hit_aux)  aux_ff <= wb_dat_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit APS double buffer

  logic                  aps1_wr;
  assign aps1_wr = wr_now & hit_aps1;

  // Software is relied on to keep K1 writes two frames apart [RQ4]
  // and to write K2 first, since the K1 write commits both [RQ5]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aps_pend_ff <= 1'b0;
      aps1_act_ff <= `LOHAPS_RST_BYTE;
      aps2_act_ff <= `LOHAPS_RST_BYTE;
    end else if (ce) begin
      if (tx_frame_start && aps_pend_ff) begin
        aps1_act_ff <= aps1_ff;                            // [RQ3]
        aps2_act_ff <= aps2_ff;                            // [RQ3]
      end
      // A write in the boundary cycle stays pending for the next frame
      aps_pend_ff <= aps1_wr | (aps_pend_ff & ~tx_frame_start);  // [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial APS input: pins synchronised, shifted MSB first, K1 then K2

  logic [1:0]            sclk_sync_ff;
  logic [1:0]            sdat_sync_ff;
  logic                  sclk_prev_ff;
  logic [15:0]           sshift_ff;
  logic [15:0]           serial_aps_ff;
  logic                  sclk_rise;

  assign sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_ff  <= 2'h0;
      sdat_sync_ff  <= 2'h0;
      sclk_prev_ff  <= 1'b0;
      sshift_ff     <= 16'h0000;
      serial_aps_ff <= 16'h0000;
    end else if (ce) begin
      sclk_sync_ff <= {sclk_sync_ff[0], serial_aps_clk};
      sdat_sync_ff <= {sdat_sync_ff[0], serial_aps_input};
      sclk_prev_ff <= sclk_sync_ff[1];
      if (sclk_rise) sshift_ff <= {sshift_ff[14:0], sdat_sync_ff[1]};
      if (tx_frame_start) serial_aps_ff <= sshift_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit overhead insertion

  logic [6:0]            rei_tx_ff;
  logic [7:0]            k1_src;
  logic [7:0]            k2_src;
  logic [7:0]            nxt_tx_out;

  assign k1_src = aps_sel ? aps1_act_ff : serial_aps_ff[15:8];   // [RQ6]
  assign k2_src = aps_sel ? aps2_act_ff : serial_aps_ff[7:0];    // [RQ6]

  // Parallel bit 7 is byte bit 1, the first one on the line [RQ2]
  assign nxt_tx_out = tx_b2_slot ? (tx_in_byte ^ {8{inject_ff}}) :   // [RQ1]
                      tx_k1_slot ? k1_src :                          // [RQ2]
                      tx_k2_slot ? k2_src :                          // [RQ2]
                      (tx_z2_slot && auto_rei && !ring_en) ? {1'b0, rei_tx_ff} :  // [RQ14]
                      tx_in_byte;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_byte <= `LOHAPS_RST_BYTE;
    end else if (ce) begin
      tx_out_byte <= nxt_tx_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive RDI / AIS persistence, sampled once per frame at K2

  logic [2:0]            rdi_cnt_ff;
  logic [2:0]            ais_cnt_ff;
  logic [2:0]            rdi_thr;
  logic [2:0]            ais_thr;
  logic                  rdi_diff;
  logic                  ais_diff;
  logic                  rdi_flip;
  logic                  ais_flip;

  assign rdi_thr  = rdi_short ? `LOHAPS_PERSIST_SHORT : `LOHAPS_PERSIST_LONG;
  assign ais_thr  = ais_short ? `LOHAPS_PERSIST_SHORT : `LOHAPS_PERSIST_LONG;
  assign rdi_diff = ((rx_in_byte[2:0] == `LOHAPS_CODE_RDI) != rdi_ff);
  assign ais_diff = ((rx_in_byte[2:0] == `LOHAPS_CODE_AIS) != ais_ff);
  assign rdi_flip = rx_k2_slot & rdi_diff & (rdi_cnt_ff == rdi_thr - 3'h1);
  assign ais_flip = rx_k2_slot & ais_diff & (ais_cnt_ff == ais_thr - 3'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdi_cnt_ff <= 3'h0;
      ais_cnt_ff <= 3'h0;
      rdi_ff     <= 1'b0;
      ais_ff     <= 1'b0;
    end else if (ce && rx_k2_slot) begin
      rdi_cnt_ff <= persist_next(rdi_cnt_ff, rdi_diff, rdi_thr);   // [RQ7]
      ais_cnt_ff <= persist_next(ais_cnt_ff, ais_diff, ais_thr);   // [RQ8]
      rdi_ff     <= rdi_ff ^ rdi_flip;                             // [RQ7]
      ais_ff     <= ais_ff ^ ais_flip;                             // [RQ8]
    end
  end

  assign remote_defect_state = rdi_ff;    // [RQ9]
  assign line_alarm_ind_out  = ais_ff;    // [RQ10]

  // The mux sits behind the alarm flop, so forcing starts in the cycle
  // after the alarm changes with no frame of delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_out_bus <= `LOHAPS_RST_BYTE;
    end else if (ce) begin
      receive_out_bus <= (force_ones && ais_ff) ? `LOHAPS_ALL_ONES : rx_in_byte;  // [RQ11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // B2 error reporting and counting

  logic [3:0]            slot_bits;
  logic [4:0]            frame_bits_ff;
  logic [4:0]            emit;
  logic [4:0]            cnt_add;
  lohaps_pkg::lohaps_pend_t pend_ff;
  lohaps_pkg::lohaps_pend_t nxt_pend;
  lohaps_pkg::lohaps_cnt_t  cnt_ff;
  logic                  pulse_ff;

  assign slot_bits = rx_b2_slot ? ones_in(rx_in_byte ^ rx_b2_calc) : 4'h0;
  // Frame totals close on the next frame start, so pulses trail by one frame
  assign emit      = out_word ? {4'h0, |frame_bits_ff} : frame_bits_ff;   // [RQ12]
  assign cnt_add   = cnt_word ? {4'h0, |frame_bits_ff} : frame_bits_ff;   // [RQ13]
  assign nxt_pend  = pend_ff - {5'h00, (pend_ff != 6'h00)} +
                     (rx_frame_start ? {1'b0, emit} : 6'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_bits_ff <= 5'h00;
      pend_ff       <= 6'h00;
      cnt_ff        <= 20'h0_0000;
      pulse_ff      <= 1'b0;
      rei_tx_ff     <= 7'h00;
    end else if (ce) begin
      frame_bits_ff <= (rx_frame_start ? 5'h00 : frame_bits_ff) + {1'b0, slot_bits};
      pend_ff       <= nxt_pend;                                  // [RQ12]
      pulse_ff      <= (pend_ff != 6'h00);                        // [RQ12]
      if (rx_frame_start) begin
        cnt_ff    <= cnt_ff + {15'h0000, cnt_add};                // [RQ13]
        rei_tx_ff <= {2'h0, emit};                                // [RQ14]
      end
    end
  end

  assign b2_error_pulse = pulse_ff;
  assign b2_err_count   = cnt_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Clear-on-read flags; a set in the read cycle wins

  logic                  rdi_set;
  logic                  ais_set;
  logic                  par_set;
  logic                  rei_set;

  assign rdi_set = ce & rdi_flip;
  assign ais_set = ce & ais_flip;
  assign par_set = ce & (slot_bits != 4'h0);
  assign rei_set = ce & rx_z2_slot & (rx_in_byte[6:0] != 7'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdi_flag_ff <= 1'b0;
      ais_flag_ff <= 1'b0;
      par_flag_ff <= 1'b0;
      rei_flag_ff <= 1'b0;
    end else if (ce) begin
      rdi_flag_ff <= rdi_set | (rdi_flag_ff & ~int_read);   // [RQ15]
      ais_flag_ff <= ais_set | (ais_flag_ff & ~int_read);   // [RQ16]
      par_flag_ff <= par_set | (par_flag_ff & ~int_read);   // [RQ17]
      rei_flag_ff <= rei_set | (rei_flag_ff & ~int_read);   // [RQ22]
    end
  end

  assign line_int = (rdi_flag_ff & int_en_ff[`LOHAPS_B_RDI_EN]) |   // [RQ18] [RQ23]
                    (ais_flag_ff & int_en_ff[`LOHAPS_B_AIS_EN]) |   // [RQ19] [RQ23]
                    (par_flag_ff & int_en_ff[`LOHAPS_B_PAR_EN]) |   // [RQ20] [RQ23]
                    (rei_flag_ff & int_en_ff[`LOHAPS_B_REI_EN]);    // [RQ21] [RQ23]

endmodule

// file: hdl/lohaps_pkg.sv
// Types shared by the line overhead / APS / alarm block.
// Assumes the constants header is included by the design file.
package lohaps_pkg;
  typedef logic [7:0]  lohaps_byte_t;
  typedef logic [19:0] lohaps_cnt_t;
  typedef logic [5:0]  lohaps_pend_t;
endpackage

// file: verif/lohaps_line_src.sv
// Line stream model: 32-byte frames shared by both directions.
// Assumes the bench changes K2 code, error mask and REI byte between slots.
`timescale 1ns/100ps
module lohaps_line_src (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] payload,
  input  wire logic [2:0] k2_code,
  input  wire logic [7:0] err_mask,
  input  wire logic [7:0] rei_val,
  output logic            frame_start,
  output logic            b2_slot,
  output logic            k1_slot,
  output logic            k2_slot,
  output logic            z2_slot,
  output logic [7:0]      rx_byte,
  output logic [7:0]      b2_calc
);
  logic [4:0] pos_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pos_ff <= 5'h00;
    else pos_ff <= pos_ff + 5'h01;
  end
  assign frame_start = rst_n && pos_ff == 5'h00;
  assign b2_slot = pos_ff == 5'h02;
  assign k1_slot = pos_ff == 5'h04;
  assign k2_slot = pos_ff == 5'h05;
  assign z2_slot = pos_ff == 5'h06;
  assign rx_byte = k2_slot ? {payload[7:3], k2_code} : (z2_slot ? rei_val : payload);
  // Outside the slot the compare byte is garbage on purpose
  assign b2_calc = b2_slot ? payload ^ err_mask : ~payload;
endmodule

// file: verif/lohaps_oh_assertions.sv
// Checker for the line overhead block, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module lohaps_oh_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        tx_b2_slot,
  input wire logic        tx_k1_slot,
  input wire logic        tx_k2_slot,
  input wire logic        tx_z2_slot,
  input wire logic [7:0]  tx_in_byte,
  input wire logic [7:0]  tx_out_byte,
  input wire logic        rx_frame_start,
  input wire logic        rx_k2_slot,
  input wire logic [7:0]  rx_in_byte,
  input wire logic [7:0]  receive_out_bus,
  input wire logic [19:0] b2_err_count,
  input wire logic        remote_defect_state,
  input wire logic        line_alarm_ind_out,
  input wire logic        line_int
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tx_plain = ce && !(tx_b2_slot || tx_k1_slot || tx_k2_slot || tx_z2_slot);
  wire k2_rdi   = rx_k2_slot && rx_in_byte[2:0] == 3'h6;
  wire k2_ais   = rx_k2_slot && rx_in_byte[2:0] == 3'h7;
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  ////////////////////////////////////////
  ack_timely_a: assert property (bus_req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_once_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdi_flip_a: assert property ($changed(remote_defect_state) |->
    $past(rx_k2_slot) && $past(k2_rdi) == remote_defect_state)
    else $error("remote defect changed without matching K2");
  ais_flip_a: assert property ($changed(line_alarm_ind_out) |->
    $past(rx_k2_slot) && $past(k2_ais) == line_alarm_ind_out)
    else $error("alarm indication changed without matching K2");
  count_step_a: assert property ($changed(b2_err_count) |-> $past(rx_frame_start))
    else $error("error count moved off a frame start");
  ones_force_a: assert property ($past(rst_n) && $past(ce)
    && receive_out_bus != $past(rx_in_byte) |->
    receive_out_bus == 8'hFF && (line_alarm_ind_out || $past(line_alarm_ind_out)))
    else $error("receive bus altered without alarm");
  int_fall_a: assert property ($fell(line_int) |-> $past(wb_ack_o))
    else $error("line interrupt dropped without bus access");
  tx_pass_a: assert property ($past(tx_plain) && $past(rst_n) |->
    tx_out_byte == $past(tx_in_byte))
    else $error("transmit byte altered outside overhead slots");
endmodule
bind lohaps_line_oh lohaps_oh_chk u_chk (.clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .tx_b2_slot, .tx_k1_slot, .tx_k2_slot, .tx_z2_slot, .tx_in_byte,
  .tx_out_byte, .rx_frame_start, .rx_k2_slot, .rx_in_byte, .receive_out_bus,
  .b2_err_count, .remote_defect_state, .line_alarm_ind_out, .line_int);

// file: verif/tb_top.sv
// Self-checking bench for the line overhead block.
// Assumes the line model's 32-cycle frames and one-wait-state bus replies.
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        aps_c = 1'b0, aps_d = 1'b0;
  logic [7:0]  adr = 8'h00, payload = 8'h00, err_mask = 8'h00, rei_val = 8'h00;
  logic [3:0]  sel = 4'h0, sl_q = 4'h0;
  logic [2:0]  k2_code = 3'h0;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic        ack, fs, b2s, k1s, k2s, z2s, b2e, rdi_pin, ais_pin, irq;
  logic [7:0]  rx_byte, b2_calc, tx_out, rob, k1_out, k2_out, z2_out, b2_out, b2_in, in_q;
  logic [7:0]  ctl, en, k1v, k2v, mask, z2_in;
  logic [19:0] cnt, c0;
  logic [15:0] seed = 16'hEFC2;
  int          errors = 0, tests_run = 0, cycles = 0, pulses = 0, n;

  always #2 clk = ~clk;
  lohaps_line_src u_line (.clk(clk), .rst_n(rst_n), .payload(payload), .k2_code(k2_code),
    .err_mask(err_mask), .rei_val(rei_val), .frame_start(fs), .b2_slot(b2s),
    .k1_slot(k1s), .k2_slot(k2s), .z2_slot(z2s), .rx_byte(rx_byte), .b2_calc(b2_calc));
  lohaps_line_oh u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tx_frame_start(fs), .tx_in_byte(payload), .tx_b2_slot(b2s),
    .tx_k1_slot(k1s), .tx_k2_slot(k2s), .tx_z2_slot(z2s), .tx_out_byte(tx_out),
    .serial_aps_clk(aps_c), .serial_aps_input(aps_d), .rx_frame_start(fs),
    .rx_in_byte(rx_byte), .rx_b2_calc(b2_calc), .rx_b2_slot(b2s), .rx_k2_slot(k2s),
    .rx_z2_slot(z2s), .receive_out_bus(rob), .b2_error_pulse(b2e), .b2_err_count(cnt),
    .remote_defect_state(rdi_pin), .line_alarm_ind_out(ais_pin), .line_int(irq));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  ////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Returns mid-frame, after every slot and pulse burst has settled
  task automatic frames(input int k);
    repeat (k) @(posedge clk iff fs);
    repeat (14) @(posedge clk);
  endtask
  task automatic ser_load(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      aps_d <= v[i];
      repeat (3) @(posedge clk);
      aps_c <= 1'b1;
      repeat (3) @(posedge clk);
      aps_c <= 1'b0;
    end
    aps_d <= ~v[0];
  endtask

  always @(posedge clk) begin
    seed <= lfsr(seed);
    payload <= seed[7:0];
  end
  // Output byte at this edge belongs to the slot flags of the previous cycle
  always @(posedge clk) begin
    if (sl_q[0]) k1_out = tx_out;
    if (sl_q[1]) k2_out = tx_out;
    if (sl_q[2]) begin
      z2_out = tx_out;
      z2_in = in_q;
    end
    if (sl_q[3]) begin
      b2_out = tx_out;
      b2_in = in_q;
    end
    sl_q = {b2s, z2s, k2s, k1s};
    in_q = payload;
    if (b2e === 1'b1) pulses++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 5; i < 10; i++) begin
      bus(1'b0, 6'(i), 8'h00);
      chk("reset_value", 32'h0, r);
    end
    bus(1'b1, 6'h02, 8'h5A);
    bus(1'b0, 6'h02, 8'h00);
    chk("unmapped", 32'h0, r);
    $display("registers done");
    bus(1'b1, 6'h05, 8'h01);
    frames(1);
    chk("b2_inject", {24'h0, ~b2_in}, {24'h0, b2_out});
    bus(1'b1, 6'h05, 8'h00);
    bus(1'b1, 6'h1F, 8'h04);
    k1v = seed[7:0];
    k2v = seed[15:8];
    bus(1'b1, 6'h07, k2v);
    bus(1'b1, 6'h06, k1v);
    frames(2);
    chk("k1_out", k1v, k1_out);
    chk("k2_out", k2v, k2_out);
    chk("b2_clean", b2_in, b2_out);
    bus(1'b1, 6'h07, ~k2v);
    frames(2);
    chk("k2_held", k2v, k2_out);
    bus(1'b0, 6'h07, 8'h00);
    chk("k2_reg", {24'h0, ~k2v}, r);
    bus(1'b1, 6'h1F, 8'h00);
    ser_load({k2v, k1v});
    frames(2);
    chk("serial_k1", k2v, k1_out);
    chk("serial_k2", k1v, k2_out);
    $display("aps done");
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 2; p++) begin
        n = p ? 3 : 5;
        ctl = (p ? 8'h10 << a : 8'h00) | (a ? 8'h40 : 8'h00);
        en = 8'h10 << a;
        bus(1'b1, 6'h08, ctl);
        bus(1'b1, 6'h09, en);
        bus(1'b0, 6'h09, 8'h00);
        for (int ph = 0; ph < 2; ph++) begin
          frames(1);
          k2_code <= ph ? 3'h0 : 3'h6 + 3'(a);
          frames(n - 1);
          bus(1'b0, 6'h08, 8'h00);
          chk("alarm_hold", ctl | (8'(ph) << a), r);
          frames(1);
          bus(1'b0, 6'h08, 8'h00);
          chk("alarm_state", ctl | (8'(1 - ph) << a), r);
          chk("alarm_pin", 1 - ph, a ? ais_pin : rdi_pin);
          if (a == 1 && ph == 0) chk("force_ones", 8'hFF, rob);
          chk("alarm_int", 1, irq);
          bus(1'b0, 6'h09, 8'h00);
          chk("change_flag", en | (8'h01 << a), r);
          bus(1'b0, 6'h09, 8'h00);
          chk("flag_cleared", en, r);
          chk("int_cleared", 0, irq);
        end
      end
    end
    $display("alarms done");
    bus(1'b1, 6'h1F, 8'h01);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 6'h08, {m[1], 3'h0, m[0], 3'h0});
      bus(1'b1, 6'h09, 8'h40);
      bus(1'b0, 6'h09, 8'h00);
      frames(1);
      mask = seed[7:0] | 8'h01;
      n = $countones(mask);
      c0 = cnt;
      pulses = 0;
      err_mask <= mask;
      frames(1);
      err_mask <= 8'h00;
      frames(1);
      chk("b2_pulses", m[0] ? 1 : n, pulses);
      chk("b2_count", m[1] ? 1 : n, {12'h0, cnt - c0});
      chk("rei_sent", m[0] ? 1 : n, z2_out);
      chk("par_int", 1, irq);
      bus(1'b0, 6'h09, 8'h00);
      chk("par_flag", 32'h44, r);
    end
    $display("b2 done");
    bus(1'b1, 6'h09, 8'h80);
    frames(1);
    rei_val <= {1'b0, seed[6:0] | 7'h01};
    frames(1);
    rei_val <= 8'h00;
    chk("rei_int", 1, irq);
    bus(1'b0, 6'h09, 8'h00);
    chk("rei_flag", 32'h88, r);
    $display("rei done");
    // Errors offered while frozen must neither count nor move the output
    ce <= 1'b0;
    err_mask <= 8'hFF;
    @(posedge clk);
    c0 = cnt;
    k1v = tx_out;
    repeat (70) @(posedge clk);
    chk("ce_hold_tx", k1v, tx_out);
    chk("ce_hold_cnt", c0, cnt);
    err_mask <= 8'h00;
    ce <= 1'b1;
    $display("enable done");
    bus(1'b1, 6'h1F, 8'h03);
    frames(1);
    chk("ring_z2", z2_in, z2_out);
    $display("ring done");
    complete_run;
  end
endmodule
